// File: tb_top.sv
// Purpose: self-checking bench for host controller and cc port device
// Assumes: 200 MHz sys_clk, shortened debounce counts
// Notes: random config drawn from a fixed seed
`timescale 1ns/1ps
module tb_top;
  localparam int unsigned DEB [4] = '{16, 12, 13, 15};
  logic        sys_clk = 1'b0;
  logic        reset_n = 1'b0;
  logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, debounce_cycles;
  logic        pready, pslverr, addr_strap_high = 1'b0, cc_active_cable = 1'b0;
  logic [1:0]  role_strap = 2'h2, cc_current_detect = 2'h0, cc_attach_state = 2'h0;
  logic [2:0]  cc_accessory = 3'h0;
  logic        cc_cable_dir = 1'b1, vbus_sense_pin = 1'b0, nk, pull;
  logic        accessory_enable, try_snk_enable, cc_term_enable, cc_fsm_hold;
  logic        pull_down_enable, pull_up_enable, soft_reset_pulse;
  logic        vbus_enable, otg_host_mode, otg_device_mode;
  logic [7:0]  rd, cfg;
  int          fails = 0, samples_checked = 0, pulses = 0;
  typec_cc_pkg::role_type port_role;

  typec_link_if link ();
  typec_cc_port_control_regs #(.DEB_CYC_0(DEB[0]), .DEB_CYC_1(DEB[1]), .DEB_CYC_2(DEB[2]),
    .DEB_CYC_3(DEB[3])) i_typec_cc_port_control_regs (.sys_clk, .reset_n, .link(link),
    .role_strap, .addr_strap_high, .cc_current_detect, .cc_accessory, .cc_active_cable,
    .cc_attach_state, .cc_cable_dir, .accessory_enable, .debounce_cycles, .port_role,
    .try_snk_enable, .cc_term_enable, .cc_fsm_hold, .pull_down_enable, .pull_up_enable,
    .soft_reset_pulse);
  typec_cc_host_ctrl i_typec_cc_host_ctrl (.sys_clk, .reset_n, .psel, .penable, .pwrite,
    .paddr, .pwdata, .prdata, .pready, .pslverr, .link(link), .vbus_sense_pin, .vbus_enable,
    .otg_host_mode, .otg_device_mode);
  typec_cc_link_sva i_typec_cc_link_sva (.sys_clk, .reset_n, .req(link.req), .wr(link.wr),
    .target(link.target), .sub_addr(link.sub_addr), .wdata(link.wdata), .ack(link.ack),
    .nack(link.nack), .rdata(link.rdata), .change_alert_pin_o(link.change_alert_pin_o),
    .change_alert_pin_oe(link.change_alert_pin_oe),
    .host_role_indicator_o(link.host_role_indicator_o),
    .host_role_indicator_oe(link.host_role_indicator_oe));

  always #2.5 sys_clk = ~sys_clk;
  always @(posedge sys_clk) if (soft_reset_pulse === 1'b1) pulses++;

  task stop_test;
    if (fails == 0 && samples_checked > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  task chk_val(input logic [31:0] e, input logic [31:0] g);
    samples_checked++;
    if (g !== e)
    begin
      fails++;
      $display("MISMATCH t=%0t exp=%h got=%h", $time, e, g);
    end
  endtask

  task chk_bit(input logic e, input logic g);
    samples_checked++;
    if (g !== e)
    begin
      fails++;
      $display("MISMATCH t=%0t exp=%h got=%h", $time, e, g);
    end
  endtask

  task apb(input logic w, input logic [11:0] a, input logic [31:0] d, output logic [31:0] q);
    @(posedge sys_clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge sys_clk);
    penable <= 1'b1;
    do
    begin
      @(posedge sys_clk);
    end
    while (pready !== 1'b1);
    q = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task link_op(input logic w, input logic [6:0] t, input logic [7:0] s, input logic [7:0] d);
    logic [31:0] q;
    apb(1'b1, typec_cc_pkg::HOST_CMD, {7'h0, w, 1'b0, t, s, d}, q);
    repeat (2) @(posedge sys_clk);
    do
    begin
      apb(1'b0, typec_cc_pkg::HOST_STAT, 32'h0, q);
    end
    while (q[0] !== 1'b0);
    rd = q[15:8];
    nk = q[1];
  endtask

  task do_reset;
    reset_n <= 1'b0;
    repeat (12) @(posedge sys_clk);
    reset_n <= 1'b1;
    repeat (3) @(posedge sys_clk);
  endtask

  function automatic typec_cc_pkg::role_type exp_role(input logic [1:0] m, input logic [1:0] s);
    if (m == 2'h0)
      m = (s == 2'h1) ? 2'h2 : (s == 2'h2) ? 2'h3 : 2'h1;
    return (m == 2'h2) ? typec_cc_pkg::ROLE_DFP :
           (m == 2'h3) ? typec_cc_pkg::ROLE_DRP : typec_cc_pkg::ROLE_UFP;
  endfunction

  initial
  begin
    repeat (20000) @(posedge sys_clk);
    fails++;
    stop_test;
  end

  initial
  begin
    void'($urandom(32'h50e8));
    do_reset;
    chk_val(typec_cc_pkg::ROLE_DRP, port_role);
    chk_bit(1'b1, accessory_enable);
    chk_val(DEB[0], debounce_cycles);
    chk_bit(1'b1, pull_up_enable);
    link_op(1'b0, 7'h47, 8'h45, 8'h00);
    chk_val(8'h00, rd);
    link_op(1'b0, 7'h47, 8'h09, 8'h00);
    chk_val(8'h20, rd & 8'hf1);
    chk_bit(1'b1, link.change_alert_level);
    link_op(1'b1, 7'h67, 8'h0a, 8'hc0);
    chk_bit(1'b1, nk);
    link_op(1'b0, 7'h47, 8'h0a, 8'h00);
    chk_bit(1'b0, nk);
    chk_val(8'h00, rd);
    for (int i = 0; i < 8; i++)
    begin
      cfg = {i[1:0], i[2:1], 2'b00, 1'($urandom), 1'($urandom)};
      pull = 1'($urandom);
      link_op(1'b1, 7'h47, 8'h0a, cfg);
      link_op(1'b1, 7'h47, 8'h45, {5'h0, pull, 2'b00});
      link_op(1'b0, 7'h47, 8'h0a, 8'h00);
      chk_val(cfg, rd);
      chk_val(DEB[i % 4], debounce_cycles);
      chk_val(exp_role(cfg[5:4], 2'h2), port_role);
      chk_bit(exp_role(cfg[5:4], 2'h2) == typec_cc_pkg::ROLE_DRP && cfg[1], try_snk_enable);
      chk_bit(cfg[0], cc_fsm_hold);
      chk_bit(!cfg[0], cc_term_enable);
      chk_bit(!cfg[0] && !pull, pull_down_enable);
      chk_bit(!cfg[0] && !pull, pull_up_enable);
    end
    link_op(1'b1, 7'h47, 8'h09, 8'h01);
    chk_bit(1'b0, accessory_enable);
    link_op(1'b1, 7'h47, 8'h09, 8'h00);
    chk_bit(1'b1, accessory_enable);
    @(posedge sys_clk);
    cc_attach_state <= typec_cc_pkg::ATT_SRC;
    vbus_sense_pin <= 1'b1;
    repeat (4) @(posedge sys_clk);
    chk_bit(1'b0, link.change_alert_level);
    chk_bit(1'b0, link.host_role_level);
    chk_bit(1'b1, vbus_enable);
    chk_bit(1'b1, otg_host_mode);
    link_op(1'b1, 7'h47, 8'h0a, 8'h10);
    chk_val(typec_cc_pkg::ROLE_DRP, port_role);
    link_op(1'b0, 7'h47, 8'h09, 8'h00);
    chk_val(8'h70, rd & 8'hf1);
    link_op(1'b1, 7'h47, 8'h09, 8'h10);
    chk_bit(1'b1, link.change_alert_level);
    @(posedge sys_clk);
    cc_attach_state <= 2'h2;
    cc_cable_dir <= 1'b0;
    repeat (4) @(posedge sys_clk);
    chk_val(typec_cc_pkg::ROLE_DRP, port_role);
    chk_bit(1'b1, link.host_role_level);
    chk_bit(1'b1, otg_device_mode);
    cc_attach_state <= 2'h0;
    repeat (4) @(posedge sys_clk);
    chk_val(typec_cc_pkg::ROLE_UFP, port_role);
    link_op(1'b1, 7'h47, 8'h09, 8'h10);
    pulses = 0;
    link_op(1'b1, 7'h47, 8'h0a, 8'h08);
    chk_val(32'd1, pulses);
    chk_bit(1'b0, link.change_alert_level);
    link_op(1'b0, 7'h47, 8'h0a, 8'h00);
    chk_val(8'h00, rd);
    @(posedge sys_clk);
    role_strap <= 2'h1;
    addr_strap_high <= 1'b1;
    cc_attach_state <= 2'h0;
    cc_cable_dir <= 1'b1;
    do_reset;
    role_strap <= 2'h0;
    repeat (3) @(posedge sys_clk);
    chk_val(typec_cc_pkg::ROLE_DFP, port_role);
    link_op(1'b0, 7'h47, 8'h0a, 8'h00);
    chk_bit(1'b1, nk);
    link_op(1'b0, 7'h67, 8'h0a, 8'h00);
    chk_bit(1'b0, nk);
    link_op(1'b0, 7'h21, 8'h09, 8'h00);
    chk_bit(1'b1, nk);
    stop_test;
  end
endmodule

// File: typec_cc_host_ctrl.sv
// Purpose: host controller end: apb-commanded register access to the port device
// Assumes: apb slave with zero wait states
// Notes: vbus and otg role follow the host-role indicator and vbus sense
`timescale 1ns/1ps
module typec_cc_host_ctrl
(
  // clock and reset
  input  wire logic        sys_clk,
  input  wire logic        reset_n,
  // apb slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  // link
  typec_link_if.host       link,
  // system
  input  wire logic        vbus_sense_pin,
  output logic             vbus_enable,
  output logic             otg_host_mode,
  output logic             otg_device_mode
);
  typedef enum logic {H_IDLE, H_REQ} host_fsm_type;

  typedef struct packed {
    host_fsm_type fsm;
    logic         req;
    logic         wr;
    logic [6:0]   tgt;
    logic [7:0]   sub;
    logic [7:0]   wdata;
    logic         nack;
    logic [7:0]   rdata;
    logic [31:0]  prdata;
    logic         vbus_en;
    logic         host_mode;
    logic         dev_mode;
  } host_state_type;

  host_state_type h_r;
  host_state_type h_nxt;

  logic id_low;

  always_comb
  begin
    h_nxt  = h_r;
    id_low = ~link.host_role_level;
    case (h_r.fsm)
      H_IDLE:
      begin
        if (psel && penable && pwrite && (paddr == typec_cc_pkg::HOST_CMD))
        begin
          h_nxt.fsm   = H_REQ;
          h_nxt.req   = 1'b1;
          h_nxt.wr    = pwdata[typec_cc_pkg::CMD_WR_BIT];
          h_nxt.tgt   = pwdata[typec_cc_pkg::CMD_TGT_LSB +: 7];
          h_nxt.sub   = pwdata[typec_cc_pkg::CMD_SUB_LSB +: 8];
          h_nxt.wdata = pwdata[typec_cc_pkg::CMD_WDATA_LSB +: 8];
        end
      end
      default:
      begin
        if (link.ack || link.nack)
        begin
          h_nxt.fsm  = H_IDLE;
          h_nxt.req  = 1'b0;
          h_nxt.nack = link.nack;
          if (link.ack && !h_r.wr)
          begin
            h_nxt.rdata = link.rdata;
          end
        end
      end
    endcase
    if (psel && !penable)
    begin
      h_nxt.prdata = 32'h0000_0000;
      if (paddr == typec_cc_pkg::HOST_STAT)
      begin
        h_nxt.prdata[typec_cc_pkg::ST_BUSY_BIT]       = (h_r.fsm == H_REQ);
        h_nxt.prdata[typec_cc_pkg::ST_NACK_BIT]       = h_r.nack;
        h_nxt.prdata[typec_cc_pkg::ST_ALERT_BIT]      = ~link.change_alert_level;
        h_nxt.prdata[typec_cc_pkg::ST_ID_BIT]         = id_low;
        h_nxt.prdata[typec_cc_pkg::ST_RDATA_LSB +: 8] = h_r.rdata;
      end
    end
    h_nxt.vbus_en   = id_low;
    h_nxt.host_mode = id_low;
    h_nxt.dev_mode  = ~id_low & vbus_sense_pin;
  end

  always_ff @(posedge sys_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      h_r     <= '0;
      h_r.fsm <= H_IDLE;
    end
    else
    begin
      h_r <= h_nxt;
    end
  end

  assign prdata          = h_r.prdata;
  assign pready          = 1'b1;
  assign pslverr         = 1'b0;
  assign link.req        = h_r.req;
  assign link.wr         = h_r.wr;
  assign link.target     = h_r.tgt;
  assign link.sub_addr   = h_r.sub;
  assign link.wdata      = h_r.wdata;
  assign vbus_enable     = h_r.vbus_en;
  assign otg_host_mode   = h_r.host_mode;
  assign otg_device_mode = h_r.dev_mode;
endmodule

// File: typec_cc_link_sva.sv
// Purpose: link checker between host controller and cc port device
// Assumes: one clock, reset_n async active low
// Notes: watches interface signals only; instantiated beside the link
`timescale 1ns/1ps
module typec_cc_link_sva
(
  // clock and reset
  input  wire logic       sys_clk,
  input  wire logic       reset_n,
  // request
  input  wire logic       req,
  input  wire logic       wr,
  input  wire logic [6:0] target,
  input  wire logic [7:0] sub_addr,
  input  wire logic [7:0] wdata,
  // answer
  input  wire logic       ack,
  input  wire logic       nack,
  input  wire logic [7:0] rdata,
  // open-drain indicators
  input  wire logic       change_alert_pin_o,
  input  wire logic       change_alert_pin_oe,
  input  wire logic       host_role_indicator_o,
  input  wire logic       host_role_indicator_oe
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!reset_n);

  sequence s_taken;
    req && !ack && !nack;
  endsequence
  sequence s_answer;
    (ack ^ nack) ##1 !req;
  endsequence
  sequence s_stranger;
    req && !ack && !nack && target != 7'h47 && target != 7'h67;
  endsequence
  sequence s_int_clear;
    ack && wr && sub_addr == 8'h09 && wdata[4];
  endsequence

  AST_ANSWER_NEXT: assert property (s_taken |=> s_answer)
    else $error("link answer not one cycle after request");
  AST_NACK_STRANGER: assert property (s_stranger |=> nack)
    else $error("foreign target not refused");
  AST_ACK_PULSE: assert property (ack |=> !ack)
    else $error("ack longer than one cycle");
  AST_REQ_STABLE: assert property (s_taken |=> $stable({wr, target, sub_addr, wdata}))
    else $error("request changed before answer");
  AST_RDATA_IDLE: assert property ((!ack || wr) |-> rdata == 8'h00)
    else $error("read data outside read answer");
  AST_ALERT_OPEN_DRAIN: assert property (change_alert_pin_oe |-> !change_alert_pin_o)
    else $error("alert pin driven high");
  AST_ROLE_OPEN_DRAIN: assert property (host_role_indicator_oe |-> !host_role_indicator_o)
    else $error("role indicator driven high");
  AST_ALERT_STICKY: assert property ($fell(change_alert_pin_oe) |-> s_int_clear)
    else $error("alert released without clear");
endmodule

// File: typec_cc_pkg.sv
// Purpose: shared constants and types for the cc port control link
// Assumes: 200 MHz sys_clk
// Notes: register offsets are byte sub-addresses on the link
package typec_cc_pkg;
  localparam int unsigned CLK_MHZ     = 200;
  localparam int unsigned CYC_PER_MS  = CLK_MHZ * 1000;
  localparam int unsigned DEB_MS_0    = 168;
  localparam int unsigned DEB_MS_1    = 118;
  localparam int unsigned DEB_MS_2    = 134;
  localparam int unsigned DEB_MS_3    = 152;

  typedef enum logic [1:0] {ROLE_UFP, ROLE_DFP, ROLE_DRP} role_type;

  localparam logic [7:0] REG_ATTACH   = 8'h09;
  localparam logic [7:0] REG_GENERAL  = 8'h0a;
  localparam logic [7:0] REG_RESIST   = 8'h45;

  localparam int ACC_OFF_BIT  = 0;
  localparam int INT_BIT      = 4;
  localparam int DIR_BIT      = 5;
  localparam int ATT_LSB      = 6;
  localparam int TERM_BIT     = 0;
  localparam int POL_LSB      = 1;
  localparam int SRST_BIT     = 3;
  localparam int MODE_LSB     = 4;
  localparam int DEB_LSB      = 6;
  localparam int PULL_BIT     = 2;
  localparam int RSVD_LSB     = 0;

  localparam logic [1:0] RSVD_RST     = 2'h0;
  localparam logic [1:0] DEB_RST      = 2'h0;
  localparam logic [1:0] MODE_STRAP   = 2'h0;
  localparam logic [1:0] MODE_UFP     = 2'h1;
  localparam logic [1:0] MODE_DFP     = 2'h2;
  localparam logic [1:0] MODE_DRP     = 2'h3;
  localparam logic [1:0] POL_STD      = 2'h0;
  localparam logic [1:0] POL_TRY_SNK  = 2'h1;
  localparam logic [1:0] ATT_NONE     = 2'h0;
  localparam logic [1:0] ATT_SRC      = 2'h1;
  localparam logic [1:0] CUR_RST      = 2'h0;
  localparam logic [2:0] ACCY_RST     = 3'h0;
  localparam logic       DIR_RST      = 1'b1;

  localparam logic [1:0] STRAP_LOW    = 2'h0;
  localparam logic [1:0] STRAP_HIGH   = 2'h1;
  localparam logic [1:0] STRAP_OPEN   = 2'h2;
  localparam logic [6:0] ADDR_LOW     = 7'h47;
  localparam logic [6:0] ADDR_HIGH    = 7'h67;

  localparam logic [11:0] HOST_CMD    = 12'h000;
  localparam logic [11:0] HOST_STAT   = 12'h004;
  localparam int CMD_WDATA_LSB = 0;
  localparam int CMD_SUB_LSB   = 8;
  localparam int CMD_TGT_LSB   = 16;
  localparam int CMD_WR_BIT    = 24;
  localparam int ST_BUSY_BIT   = 0;
  localparam int ST_NACK_BIT   = 1;
  localparam int ST_ALERT_BIT  = 2;
  localparam int ST_ID_BIT     = 3;
  localparam int ST_RDATA_LSB  = 8;
endpackage

// File: typec_cc_port_control_regs.sv
// Purpose: cc port control register bank of the type-c port device
// Assumes: strap pins steady at reset release; cc status from cc logic
// Notes: debounce counts are parameters so a bench can shorten them
// Notes on behaviour
// - accessory-off bit disables ufp accessory support
// - debounce field picks 168/118/134/152 ms
// - mode field: strap, ufp, dfp, drp-from-sink
// - mode change applied only while unattached
// - board straps address pin for register control
// - soft reset bit starts reset, self-clears
// - soft reset clears attach status fields
// - drp policy field selects standard or try.snk
// - termination-off removes termination, holds cc fsm
// - pull-off disables both pull-down and pull-up
// - software keeps reserved resistor bits default
// - address strap picks 0x47 low, 0x67 otherwise
// - change alert is open-drain register-change notice
// - host-role indicator low when drp attached source
// - otg controller follows indicator and vbus sense
// - source enables vbus only after attached source
// - default mode, open strap gives drp
// - default mode, strap high gives dfp
// - status change sets sticky flag, alert low
// - role strap sampled only at reset release
`timescale 1ns/1ps
module typec_cc_port_control_regs #(
  parameter int unsigned DEB_CYC_0 = typec_cc_pkg::DEB_MS_0 * typec_cc_pkg::CYC_PER_MS,
  parameter int unsigned DEB_CYC_1 = typec_cc_pkg::DEB_MS_1 * typec_cc_pkg::CYC_PER_MS,
  parameter int unsigned DEB_CYC_2 = typec_cc_pkg::DEB_MS_2 * typec_cc_pkg::CYC_PER_MS,
  parameter int unsigned DEB_CYC_3 = typec_cc_pkg::DEB_MS_3 * typec_cc_pkg::CYC_PER_MS
)
(
  // clock and reset
  input  wire logic                   sys_clk,
  input  wire logic                   reset_n,
  // link
  typec_link_if.dev                   link,
  // straps
  input  wire logic [1:0]             role_strap,
  input  wire logic                   addr_strap_high,
  // status from cc logic
  input  wire logic [1:0]             cc_current_detect,
  input  wire logic [2:0]             cc_accessory,
  input  wire logic                   cc_active_cable,
  input  wire logic [1:0]             cc_attach_state,
  input  wire logic                   cc_cable_dir,
  // controls to cc logic
  output logic                        accessory_enable,
  output logic [31:0]                 debounce_cycles,
  output typec_cc_pkg::role_type      port_role,
  output logic                        try_snk_enable,
  output logic                        cc_term_enable,
  output logic                        cc_fsm_hold,
  output logic                        pull_down_enable,
  output logic                        pull_up_enable,
  output logic                        soft_reset_pulse
);
  typedef struct packed {
    logic                   acc_off;
    logic [1:0]             deb;
    logic [1:0]             mode;
    logic [1:0]             pol;
    logic                   term_off;
    logic                   pull_off;
    logic [1:0]             rsvd;
    logic                   srst;
    logic                   int_st;
    logic [1:0]             cur;
    logic [2:0]             accy;
    logic                   act;
    logic [1:0]             att;
    logic                   dir;
    typec_cc_pkg::role_type role;
    typec_cc_pkg::role_type strap_role;
    logic                   strap_done;
    logic [6:0]             own_addr;
    logic                   id_low;
    logic                   ack;
    logic                   nack;
    logic [7:0]             rdata;
    logic [31:0]            deb_cyc;
  } dev_state_type;

  dev_state_type s_r;
  dev_state_type s_nxt;

  function automatic typec_cc_pkg::role_type strap_decode(input logic [1:0] strap);
    if (strap == typec_cc_pkg::STRAP_HIGH)
    begin
      strap_decode = typec_cc_pkg::ROLE_DFP;
    end
    else if (strap == typec_cc_pkg::STRAP_OPEN)
    begin
      strap_decode = typec_cc_pkg::ROLE_DRP;
    end
    else
    begin
      strap_decode = typec_cc_pkg::ROLE_UFP;
    end
  endfunction

  function automatic typec_cc_pkg::role_type mode_decode(input logic [1:0] mode,
                                                        input typec_cc_pkg::role_type strap);
    case (mode)
      typec_cc_pkg::MODE_UFP: mode_decode = typec_cc_pkg::ROLE_UFP;
      typec_cc_pkg::MODE_DFP: mode_decode = typec_cc_pkg::ROLE_DFP;
      typec_cc_pkg::MODE_DRP: mode_decode = typec_cc_pkg::ROLE_DRP;
      default:                mode_decode = strap;
    endcase
  endfunction

  logic       take;
  logic       match;
  logic       attached;
  logic [8:0] status_now;
  logic [8:0] status_old;

  always_comb
  begin
    s_nxt      = s_r;
    take       = link.req & ~s_r.ack & ~s_r.nack;
    match      = (link.target == s_r.own_addr);
    attached   = (cc_attach_state != typec_cc_pkg::ATT_NONE);
    status_now = {cc_current_detect, cc_accessory, cc_active_cable, cc_attach_state,
                  cc_cable_dir};
    status_old = {s_r.cur, s_r.accy, s_r.act, s_r.att, s_r.dir};
    s_nxt.ack  = take & match;
    s_nxt.nack = take & ~match;
    s_nxt.srst = 1'b0;
    if (!s_r.strap_done)
    begin
      s_nxt.strap_done = 1'b1;
      s_nxt.strap_role = strap_decode(role_strap);
      s_nxt.role       = strap_decode(role_strap);
      s_nxt.own_addr   = addr_strap_high ? typec_cc_pkg::ADDR_HIGH
                                         : typec_cc_pkg::ADDR_LOW;
    end
    else if (!attached)
    begin
      s_nxt.role = mode_decode(s_r.mode, s_r.strap_role);
    end
    if (take && match && link.wr)
    begin
      if (link.sub_addr == typec_cc_pkg::REG_ATTACH)
      begin
        s_nxt.acc_off = link.wdata[typec_cc_pkg::ACC_OFF_BIT];
        if (link.wdata[typec_cc_pkg::INT_BIT])
        begin
          s_nxt.int_st = 1'b0;
        end
      end
      else if (link.sub_addr == typec_cc_pkg::REG_GENERAL)
      begin
        s_nxt.deb      = link.wdata[typec_cc_pkg::DEB_LSB +: 2];
        s_nxt.mode     = link.wdata[typec_cc_pkg::MODE_LSB +: 2];
        s_nxt.srst     = link.wdata[typec_cc_pkg::SRST_BIT];
        s_nxt.pol      = link.wdata[typec_cc_pkg::POL_LSB +: 2];
        s_nxt.term_off = link.wdata[typec_cc_pkg::TERM_BIT];
      end
      else if (link.sub_addr == typec_cc_pkg::REG_RESIST)
      begin
        s_nxt.pull_off = link.wdata[typec_cc_pkg::PULL_BIT];
        s_nxt.rsvd     = link.wdata[typec_cc_pkg::RSVD_LSB +: 2];
      end
    end
    if (s_r.srst)
    begin
      s_nxt.cur  = typec_cc_pkg::CUR_RST;
      s_nxt.accy = typec_cc_pkg::ACCY_RST;
      s_nxt.act  = 1'b0;
      s_nxt.att  = typec_cc_pkg::ATT_NONE;
      s_nxt.dir  = typec_cc_pkg::DIR_RST;
    end
    else
    begin
      {s_nxt.cur, s_nxt.accy, s_nxt.act, s_nxt.att, s_nxt.dir} = status_now;
      if (s_r.strap_done && (status_now != status_old))
      begin
        s_nxt.int_st = 1'b1;
      end
    end
    s_nxt.rdata = 8'h00;
    if (take && match && !link.wr)
    begin
      if (link.sub_addr == typec_cc_pkg::REG_ATTACH)
      begin
        s_nxt.rdata[typec_cc_pkg::ATT_LSB +: 2]    = s_r.att;
        s_nxt.rdata[typec_cc_pkg::DIR_BIT]         = s_r.dir;
        s_nxt.rdata[typec_cc_pkg::INT_BIT]         = s_r.int_st;
        s_nxt.rdata[typec_cc_pkg::ACC_OFF_BIT]     = s_r.acc_off;
      end
      else if (link.sub_addr == typec_cc_pkg::REG_GENERAL)
      begin
        s_nxt.rdata[typec_cc_pkg::DEB_LSB +: 2]    = s_r.deb;
        s_nxt.rdata[typec_cc_pkg::MODE_LSB +: 2]   = s_r.mode;
        s_nxt.rdata[typec_cc_pkg::POL_LSB +: 2]    = s_r.pol;
        s_nxt.rdata[typec_cc_pkg::TERM_BIT]        = s_r.term_off;
      end
      else if (link.sub_addr == typec_cc_pkg::REG_RESIST)
      begin
        s_nxt.rdata[typec_cc_pkg::PULL_BIT]        = s_r.pull_off;
        s_nxt.rdata[typec_cc_pkg::RSVD_LSB +: 2]   = s_r.rsvd;
      end
    end
    case (s_r.deb)
      2'h1:    s_nxt.deb_cyc = DEB_CYC_1;
      2'h2:    s_nxt.deb_cyc = DEB_CYC_2;
      2'h3:    s_nxt.deb_cyc = DEB_CYC_3;
      default: s_nxt.deb_cyc = DEB_CYC_0;
    endcase
    s_nxt.id_low = (s_r.role == typec_cc_pkg::ROLE_DRP) &&
                   (s_r.att == typec_cc_pkg::ATT_SRC);
  end

  always_ff @(posedge sys_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      s_r            <= '0;
      s_r.deb        <= typec_cc_pkg::DEB_RST;
      s_r.mode       <= typec_cc_pkg::MODE_STRAP;
      s_r.pol        <= typec_cc_pkg::POL_STD;
      s_r.rsvd       <= typec_cc_pkg::RSVD_RST;
      s_r.dir        <= typec_cc_pkg::DIR_RST;
      s_r.role       <= typec_cc_pkg::ROLE_UFP;
      s_r.strap_role <= typec_cc_pkg::ROLE_UFP;
      s_r.own_addr   <= typec_cc_pkg::ADDR_LOW;
      s_r.deb_cyc    <= DEB_CYC_0;
    end
    else
    begin
      s_r <= s_nxt;
    end
  end

  assign link.ack                    = s_r.ack;
  assign link.nack                   = s_r.nack;
  assign link.rdata                  = s_r.rdata;
  assign link.change_alert_pin_o     = 1'b0;
  assign link.change_alert_pin_oe    = s_r.int_st;
  assign link.host_role_indicator_o  = 1'b0;
  assign link.host_role_indicator_oe = s_r.id_low;
  assign accessory_enable = ~s_r.acc_off;
  assign debounce_cycles  = s_r.deb_cyc;
  assign port_role        = s_r.role;
  assign try_snk_enable   = (s_r.role == typec_cc_pkg::ROLE_DRP) &&
                            (s_r.pol == typec_cc_pkg::POL_TRY_SNK);
  assign cc_term_enable   = ~s_r.term_off;
  assign cc_fsm_hold      = s_r.term_off;
  assign pull_down_enable = ~s_r.term_off & ~s_r.pull_off;
  assign pull_up_enable   = ~s_r.term_off & ~s_r.pull_off;
  assign soft_reset_pulse = s_r.srst;
endmodule

// File: typec_link_if.sv
// Purpose: link between the host controller and the cc port device
// Assumes: one clock, request held until ack or nack
// Notes: open-drain pins resolved here from output and enable
`timescale 1ns/1ps
interface typec_link_if;
  // register access
  logic       req;
  logic       wr;
  logic [6:0] target;
  logic [7:0] sub_addr;
  logic [7:0] wdata;
  logic       ack;
  logic       nack;
  logic [7:0] rdata;
  // open-drain indicators
  logic       change_alert_pin_o;
  logic       change_alert_pin_oe;
  logic       host_role_indicator_o;
  logic       host_role_indicator_oe;
  logic       change_alert_level;
  logic       host_role_level;

  assign change_alert_level = change_alert_pin_oe ? change_alert_pin_o : 1'b1;
  assign host_role_level    = host_role_indicator_oe ? host_role_indicator_o : 1'b1;

  modport dev
  (
    input  req, wr, target, sub_addr, wdata,
    output ack, nack, rdata,
    output change_alert_pin_o, change_alert_pin_oe,
    output host_role_indicator_o, host_role_indicator_oe
  );
  modport host
  (
    output req, wr, target, sub_addr, wdata,
    input  ack, nack, rdata,
    input  change_alert_level, host_role_level
  );
endinterface
